// ---- core/asl_pkg.sv ----
// asl_pkg: constants, register map and carrier types of the latched alarm block
// assumes a 32-bit AXI4-Lite master and one 100 MHz clock domain
package asl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 16;
    localparam int SAFETY_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RAW = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PIN = 8'h0c;

    // alarm bit positions, shared by latched, raw and mask registers
    localparam int BIT_SAFETY_FAULT_A = 15;
    localparam int BIT_SAFETY_FAULT_B = 14;
    localparam int BIT_SAFETY_WARN_A = 13;
    localparam int BIT_SAFETY_WARN_B = 12;
    localparam int BIT_CHG_OFF = 11;
    localparam int BIT_DSG_OFF = 10;
    localparam int BIT_SHUTDOWN_V = 9;
    localparam int BIT_BALANCING = 8;
    localparam int BIT_COMPLETE_SCAN = 7;
    localparam int BIT_VOLTAGE_SCAN = 6;
    localparam int BIT_WAKE = 5;
    localparam int BIT_SLEEP = 4;
    localparam int BIT_TIMER = 3;
    localparam int BIT_STARTUP = 2;
    localparam int BIT_CHG_DETECT = 1;
    localparam int BIT_FULL_RESET = 0;

    // pin status register fields
    localparam int BIT_PIN_LOW = 0;
    localparam int BIT_PIN_DRIVEN = 1;

    // reset values
    localparam logic [FLAG_W-1:0] FLAGS_RST = 16'h0001;
    localparam logic [FLAG_W-1:0] MASK_RST = 16'hffff;
    // sources whose latch does not depend on the mask
    localparam logic [FLAG_W-1:0] MASK_BYPASS = 16'h0203;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [SAFETY_W-1:0] safety_fault_a;
        logic [SAFETY_W-1:0] safety_fault_b;
        logic [SAFETY_W-1:0] safety_warn_a;
        logic [SAFETY_W-1:0] safety_warn_b;
        logic charge_driver;
        logic discharge_driver;
        logic cell_below_shutdown;
        logic stack_below_shutdown;
        logic balancing_active;
        logic complete_scan_pulse;
        logic voltage_scan_pulse;
        logic wake_pulse;
        logic sleep_entry_pulse;
        logic timer_expired_pulse;
        logic startup_done_pulse;
        logic charger_detect_deb;
        logic full_reset_ind;
    } asl_src_s;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } asl_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } asl_axi_rsp_s;

endpackage

// ---- core/asl_alarm_latch.sv ----
// asl_alarm_latch: sticky alarm flags with mask, raw view and open-drain alert
// assumes synchronous source inputs and an AXI4-Lite master on ref_clk
//
// Notes on behaviour
// - sixteen sticky flags; any set pulls alert low
// - writing one clears a flag; zero keeps
// - bit 15 latches on safety fault A
// - bit 14 latches on safety fault B
// - bit 13 latches on safety warning A
// - bit 12 latches on safety warning B
// - bit 11 latches while charge driver off
// - bit 10 latches while discharge driver off
// - bit 9 latches on shutdown voltage, unmasked
// - bit 8 latches while balancing active
// - bit 7 latches on complete scan done
// - bit 6 latches on voltage scan done
// - bit 5 latches on wake from sleep
// - bit 4 latches on sleep entry
// - bit 3 latches on timer expiry
// - bit 2 latches on startup sequence done
// - bit 1 latches on each charger detect toggle
// - bit 0 latches on full reset indication
// - raw source values readable; only selected latch, except bits 9, 1 and 0, which latch regardless of mask
// - writable mask selects latching sources, configurable default
// - alert released, not driven high, when clear
`timescale 1ns/1ps

module asl_alarm_latch
    import asl_pkg::*;
#(
    parameter logic [asl_pkg::FLAG_W-1:0] DEFAULT_ALARM_MASK = asl_pkg::MASK_RST
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // alarm sources
    input asl_pkg::asl_src_s src,
    // register bus
    input asl_pkg::asl_axi_req_s axi_req,
    output asl_pkg::asl_axi_rsp_s axi_rsp,
    // open-drain alert pin
    input wire logic alert_n_in,
    output logic alert_n_out,
    output logic alert_n_oe
);
    import asl_pkg::*;

    // raw source view
    logic [FLAG_W-1:0] raw_view;
    logic [FLAG_W-1:0] latch_src;
    logic [FLAG_W-1:0] enable_eff;
    logic [FLAG_W-1:0] set_vec;
    logic [FLAG_W-1:0] clr_vec;
    logic [FLAG_W-1:0] wr_lanes;
    logic cd_toggle;

    // registers
    logic [FLAG_W-1:0] flags_r;
    logic [FLAG_W-1:0] flags_nxt;
    logic [FLAG_W-1:0] mask_r;
    logic [FLAG_W-1:0] mask_nxt;
    logic [FLAG_W-1:0] raw_r;
    logic cd_prev_r;
    logic cd_seen_r;
    logic pin_low_r;
    logic alert_oe_r;
    logic alert_out_r;

    // write channel state
    logic aw_full_r;
    logic aw_full_nxt;
    logic w_full_r;
    logic w_full_nxt;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [DATA_W-1:0] w_data_r;
    logic [3:0] w_strb_r;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // read channel state
    logic arready_r;
    logic rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0] rresp_r;

    // handshakes and decode
    wire aw_hs = axi_req.awvalid & awready_r;
    wire w_hs = axi_req.wvalid & wready_r;
    wire b_hs = bvalid_r & axi_req.bready;
    wire ar_hs = axi_req.arvalid & arready_r;
    wire r_hs = rvalid_r & axi_req.rready;
    wire wr_do = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_flags = wr_do & (aw_addr_r == OFS_FLAGS);
    wire wr_mask = wr_do & (aw_addr_r == OFS_MASK);
    wire wr_hit = (aw_addr_r == OFS_FLAGS) | (aw_addr_r == OFS_MASK)
        | (aw_addr_r == OFS_RAW) | (aw_addr_r == OFS_PIN);
    wire rd_flags = axi_req.araddr == OFS_FLAGS;
    wire rd_raw = axi_req.araddr == OFS_RAW;
    wire rd_mask = axi_req.araddr == OFS_MASK;
    wire rd_pin = axi_req.araddr == OFS_PIN;
    wire rd_hit = rd_flags | rd_raw | rd_mask | rd_pin;
    wire [FLAG_W-1:0] pin_word = {{(FLAG_W-2){1'b0}}, alert_oe_r, pin_low_r};
    wire [FLAG_W-1:0] rd_word = rd_flags ? flags_r
        : rd_raw ? raw_r
        : rd_mask ? mask_r
        : rd_pin ? pin_word
        : '0;
    wire [DATA_W-1:0] rd_data = {{(DATA_W-FLAG_W){1'b0}}, rd_word};

    // raw view: what each source shows right now
    assign raw_view[BIT_SAFETY_FAULT_A] = |src.safety_fault_a;
    assign raw_view[BIT_SAFETY_FAULT_B] = |src.safety_fault_b;
    assign raw_view[BIT_SAFETY_WARN_A] = |src.safety_warn_a;
    assign raw_view[BIT_SAFETY_WARN_B] = |src.safety_warn_b;
    assign raw_view[BIT_CHG_OFF] = ~src.charge_driver;
    assign raw_view[BIT_DSG_OFF] = ~src.discharge_driver;
    assign raw_view[BIT_SHUTDOWN_V] = src.cell_below_shutdown | src.stack_below_shutdown;
    assign raw_view[BIT_BALANCING] = src.balancing_active;
    assign raw_view[BIT_COMPLETE_SCAN] = src.complete_scan_pulse;
    assign raw_view[BIT_VOLTAGE_SCAN] = src.voltage_scan_pulse;
    assign raw_view[BIT_WAKE] = src.wake_pulse;
    assign raw_view[BIT_SLEEP] = src.sleep_entry_pulse;
    assign raw_view[BIT_TIMER] = src.timer_expired_pulse;
    assign raw_view[BIT_STARTUP] = src.startup_done_pulse;
    assign raw_view[BIT_CHG_DETECT] = src.charger_detect_deb;
    assign raw_view[BIT_FULL_RESET] = src.full_reset_ind;

    // the raw view of bit 1 is the detector level, but what latches is its change
    // the first sample after reset only seeds the history, so reset itself is no toggle
    assign cd_toggle = cd_seen_r & (src.charger_detect_deb != cd_prev_r);

    always_comb
    begin
        latch_src = raw_view;
        latch_src[BIT_CHG_DETECT] = cd_toggle;
    end

    // shutdown voltage, detector toggle and reset indication latch regardless of mask
    assign enable_eff = mask_r | MASK_BYPASS;
    assign set_vec = latch_src & enable_eff;

    // byte lanes of the write strobe
    assign wr_lanes = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign clr_vec = wr_flags ? (w_data_r[FLAG_W-1:0] & wr_lanes) : '0;

    // per-bit sticky flag update
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi = gi + 1)
        begin : g_flag
            // set term last, so a same-cycle clear never hides an event
            assign flags_nxt[gi] = (flags_r[gi] & ~clr_vec[gi]) | set_vec[gi];
        end
    endgenerate

    assign mask_nxt = wr_mask ? ((mask_r & ~wr_lanes) | (w_data_r[FLAG_W-1:0] & wr_lanes)) : mask_r;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flags_r <= FLAGS_RST;
            mask_r <= DEFAULT_ALARM_MASK;
            raw_r <= '0;
            cd_prev_r <= 1'b0;
            cd_seen_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            raw_r <= raw_view;
            cd_prev_r <= src.charger_detect_deb;
            cd_seen_r <= 1'b1;
        end
    end

    // alert pin: pulled low while any flag is set, otherwise released
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            alert_oe_r <= 1'b1;
            alert_out_r <= 1'b0;
            pin_low_r <= 1'b0;
        end
        else
        begin
            alert_oe_r <= |flags_nxt;
            alert_out_r <= 1'b0;
            pin_low_r <= ~alert_n_in;
        end
    end

    assign alert_n_oe = alert_oe_r;
    assign alert_n_out = alert_out_r;

    // write path: address and data taken in either order, one write at a time
    assign aw_full_nxt = (aw_full_r | aw_hs) & ~wr_do;
    assign w_full_nxt = (w_full_r | w_hs) & ~wr_do;
    assign bvalid_nxt = wr_do | (bvalid_r & ~b_hs);
    assign bresp_nxt = wr_do ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    assign awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
    assign wready_nxt = ~w_full_nxt & ~bvalid_nxt;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // payload capture has no reset; it is only read once its full flag is set
    always_ff @(posedge ref_clk)
    begin
        if (aw_hs)
        begin
            aw_addr_r <= axi_req.awaddr;
        end
        if (w_hs)
        begin
            w_data_r <= axi_req.wdata;
            w_strb_r <= axi_req.wstrb;
        end
    end

    // read path: data registered on the address handshake
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r_hs)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
        else if (!rvalid_r)
        begin
            arready_r <= 1'b1;
        end
    end

    assign axi_rsp.awready = awready_r;
    assign axi_rsp.wready = wready_r;
    assign axi_rsp.bresp = bresp_r;
    assign axi_rsp.bvalid = bvalid_r;
    assign axi_rsp.arready = arready_r;
    assign axi_rsp.rdata = rdata_r;
    assign axi_rsp.rresp = rresp_r;
    assign axi_rsp.rvalid = rvalid_r;

endmodule

// ---- testbench/asl_alarm_latch_properties.sv ----
// asl_alarm_latch_properties: port-level checks of the latched alarm block
// assumes it is bound into every asl_alarm_latch instance
`timescale 1ns/1ps

module asl_alarm_latch_properties
    import asl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // sources and bus
    input asl_pkg::asl_src_s src,
    input asl_pkg::asl_axi_req_s axi_req,
    input asl_pkg::asl_axi_rsp_s axi_rsp,
    // alert pin
    input wire logic alert_n_in,
    input wire logic alert_n_out,
    input wire logic alert_n_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_open_drain: assert property (alert_n_out == 1'b0)
        else $error("alert line driven high");
    a_reset_alert: assert property (disable iff (1'b0) !nrst |-> alert_n_oe)
        else $error("alert not asserted in reset");
    a_shutdown_alert: assert property (src.cell_below_shutdown || src.stack_below_shutdown |=> alert_n_oe)
        else $error("shutdown did not assert alert");
    a_full_reset_alert: assert property (src.full_reset_ind |=> alert_n_oe)
        else $error("reset indication did not assert alert");
    // the first edge after release only seeds the detector history
    a_detect_toggle: assert property ($past(nrst) && src.charger_detect_deb != $past(src.charger_detect_deb)
        |=> alert_n_oe)
        else $error("detector toggle did not assert alert");
    a_clear_by_write: assert property ($fell(alert_n_oe) |-> $rose(axi_rsp.bvalid))
        else $error("alert released without a write");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer late or early");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer missing");
    a_aw_refuse: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready [*2])
        else $error("second write address accepted");

    cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
    cover property ($fell(alert_n_oe));
    cover property (axi_rsp.rvalid);
endmodule

bind asl_alarm_latch asl_alarm_latch_properties asl_alarm_latch_properties_inst (.ref_clk(ref_clk), .nrst(nrst),
    .src(src), .axi_req(axi_req), .axi_rsp(axi_rsp), .alert_n_in(alert_n_in), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe));

// ---- testbench/asl_host_model.sv ----
// asl_host_model: host side of the open-drain alert line
// assumes the host holds the only pull-up on the line
`timescale 1ns/1ps

module asl_host_model
(
    // alert pin
    input wire logic alert_n_out,
    input wire logic alert_n_oe,
    output logic alert_n_in
);
    // released line reads high through the pull-up, never left floating
    assign alert_n_in = alert_n_oe ? alert_n_out : 1'b1;
endmodule

// ---- testbench/asl_alarm_latch_bench.sv ----
// asl_alarm_latch_bench: register-level tests of the latched alarm block
// assumes asl_host_model pulls the alert line up when released
`timescale 1ns/1ps

module asl_alarm_latch_bench;
    import asl_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b1;
    asl_src_s src;
    asl_axi_req_s axi_req = '0;
    asl_axi_rsp_s axi_rsp;
    logic alert_n_in;
    logic alert_n_out;
    logic alert_n_oe;
    logic det = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #5 ref_clk = ~ref_clk;

    asl_alarm_latch asl_alarm_latch_inst (.ref_clk(ref_clk), .nrst(nrst), .src(src), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .alert_n_in(alert_n_in), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
    asl_host_model asl_host_model_inst (.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .alert_n_in(alert_n_in));

    // one source per flag bit; summaries use the top, bottom or an inner bit to show any bit counts
    function automatic asl_src_s mk(input logic [15:0] v);
        asl_src_s s;
        s = '0;
        s.safety_fault_a = {v[15], 7'h0};
        s.safety_fault_b = {7'h0, v[14]};
        s.safety_warn_a = {3'h0, v[13], 4'h0};
        s.safety_warn_b = {1'b0, v[12], 6'h0};
        s.charge_driver = !v[11];
        s.discharge_driver = !v[10];
        // bit 9 alone uses the stack input, together with bit 8 the cell input
        s.cell_below_shutdown = v[9] & v[8];
        s.stack_below_shutdown = v[9] & !v[8];
        s.balancing_active = v[8];
        s.complete_scan_pulse = v[7];
        s.voltage_scan_pulse = v[6];
        s.wake_pulse = v[5];
        s.sleep_entry_pulse = v[4];
        s.timer_expired_pulse = v[3];
        s.startup_done_pulse = v[2];
        s.charger_detect_deb = det;
        s.full_reset_ind = v[0];
        return s;
    endfunction

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        axi_req.awaddr <= a;
        axi_req.wdata <= {16'h0, d};
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (axi_rsp.awready)
                axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready)
                axi_req.wvalid <= 1'b0;
        end
        while (!axi_rsp.bvalid);
        chk("bresp", {32'h0, r}, {32'h0, axi_rsp.bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (axi_rsp.arready)
                axi_req.arvalid <= 1'b0;
        end
        while (!axi_rsp.rvalid);
        chk("rdata", {r, 16'h0, e}, {axi_rsp.rresp, axi_rsp.rdata});
    endtask

    task automatic fire(input logic [15:0] v);
        src <= mk(v);
        @(posedge ref_clk);
        src <= mk(16'h0);
    endtask

    task automatic test_done();
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // whole run needs a few hundred cycles
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            test_done();
        end
    end

    initial
    begin
        // a real falling edge at time zero, so the asynchronous reset fires before the first clock
        nrst <= 1'b0;
        src = mk(16'h0);
        axi_req.wstrb = 4'hf;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(OFS_FLAGS, 16'h0001, RESP_OKAY);
        rd(OFS_MASK, 16'hffff, RESP_OKAY);
        rd(OFS_PIN, 16'h0003, RESP_OKAY);
        rd(OFS_RAW, 16'h0000, RESP_OKAY);
        wr(OFS_FLAGS, 16'h0001, RESP_OKAY);
        rd(OFS_PIN, 16'h0000, RESP_OKAY);
        for (int i = 0; i < 16; i++)
        begin
            if (i != 1)
            begin
                fire(16'h1 << i);
                rd(OFS_FLAGS, 16'h1 << i, RESP_OKAY);
                wr(OFS_FLAGS, 16'h1 << i, RESP_OKAY);
                rd(OFS_FLAGS, 16'h0, RESP_OKAY);
            end
        end
        // masked sources stay out; shutdown and reset indication ignore the mask
        wr(OFS_MASK, 16'h0000, RESP_OKAY);
        fire(16'hfffd);
        rd(OFS_FLAGS, 16'h0201, RESP_OKAY);
        wr(OFS_FLAGS, 16'hffff, RESP_OKAY);
        wr(OFS_MASK, 16'hffff, RESP_OKAY);
        det = 1'b1;
        src <= mk(16'h0);
        // the toggle latches at the next edge; a read taken there would still see the old flags
        @(posedge ref_clk);
        rd(OFS_FLAGS, 16'h0002, RESP_OKAY);
        wr(OFS_FLAGS, 16'h0002, RESP_OKAY);
        rd(OFS_FLAGS, 16'h0000, RESP_OKAY);
        fire(16'h0018);
        wr(OFS_FLAGS, 16'h0008, RESP_OKAY);
        rd(OFS_FLAGS, 16'h0010, RESP_OKAY);
        src <= mk(16'h0100);
        wr(OFS_FLAGS, 16'h0110, RESP_OKAY);
        rd(OFS_FLAGS, 16'h0100, RESP_OKAY);
        rd(OFS_RAW, 16'h0102, RESP_OKAY);
        src <= mk(16'h0);
        wr(OFS_FLAGS, 16'hffff, RESP_OKAY);
        rd(OFS_FLAGS, 16'h0000, RESP_OKAY);
        // only the low byte lane is written, the high byte of the mask keeps its ones
        axi_req.wstrb <= 4'h1;
        wr(OFS_MASK, 16'h0000, RESP_OKAY);
        rd(OFS_MASK, 16'hff00, RESP_OKAY);
        wr(8'h10, 16'hffff, RESP_SLVERR);
        rd(8'h10, 16'h0000, RESP_SLVERR);
        test_done();
    end
endmodule
